// ===== hdl/omc_ctrl.sv
// Functional notes
// - after reset the device runs single-clock from the high-frequency clock
// - single-clock: only hf oscillator runs, system clock from hf
// - lf oscillator pins are I/O in single-clock, oscillator pins in dual
// - idle request in hf single run halts cpu and watchdog, peripherals keep hf
// - peripheral or external interrupt ends single idle back to single run
// - on wake: service interrupt if master enable, else resume next instruction
// - clock-gate halt in hf single run stops all but time base timer
// - falling edge of time base source ends timebase halt, back to origin
// - timebase halt entry and exit ignore timebase enable; service needs all three
// - hf timebase halt entered with timebase enable sets its latch on return
// - dual: system clock hf in hf run/idle, lf in lf run/sleep
// - reset always lands single-clock; firmware starts lf oscillator itself
// - dual hf run: cpu on hf, peripherals on hf and lf
// - clock select moves between dual hf run and lf run with hf on
// - hf enable moves between lf run hf off and lf run hf on
// - low divider stages stop while hf oscillator is off in lf states
// - dual hf idle halts cpu and watchdog, returns to dual hf run
// - lf sleep hf off halts cpu, peripherals on lf, returns to lf run hf off
// - lf sleep hf on is lf run hf on with cpu idled
// - clock-gate halt in lf run hf off enters lf timebase halt
// - halt-all stops everything incl oscillators; left only by wake pin
// - after warm-up return to previous state and resume next instruction
// - idle request bit reads zero once idle or sleep is left
// - clock-gate halt bit reads zero once timebase halt is left
// - illegal oscillator enable clearing generates a reset
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module omc_ctrl #(
  parameter int unsigned WARM_CYCLES = omc_pkg::WARMUP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic peripheral_irq,
  input wire logic external_irq,
  input wire logic master_irq_enable,
  input wire logic timebase_irq_enable,
  input wire logic wake_pin,
  input wire logic timebase_src,
  output logic [omc_pkg::TB_SEL_W-1:0] timebase_source_select,
  output logic timebase_enable,
  output logic cpu_wdt_clk_en,
  output logic periph_hf_clk_en,
  output logic periph_lf_clk_en,
  output logic tbt_clk_en,
  output logic hf_osc_run,
  output logic lf_osc_run,
  output logic sysclk_is_lf,
  output logic lf_pins_are_io,
  output logic div_low_stages_run,
  output logic osc_fault_reset,
  output logic timebase_irq_latch_set,
  output logic timebase_irq_service,
  output logic wake_irq_service,
  output logic wake_resume_next
);
  import omc_pkg::*;

  logic rst_n_s;
  logic wake_rise;
  logic tb_fall;
  logic dp_wr_r;
  logic [ADDR_LSB_W-1:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic hf_en_r;
  logic lf_en_r;
  logic tb_en_r;
  logic [TB_SEL_W-1:0] tb_sel_r;
  logic tb_at_entry_r;
  logic [WARM_W-1:0] warm_cnt_r;
  omc_state_t state_r;
  omc_state_t state_nxt;
  omc_state_t ret_r;
  omc_state_t mode_s;
  logic [7:0] wd;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_tb;
  logic halt_req;
  logic idle_req;
  logic tgh_req;
  logic osc_fault;
  logic any_irq;
  logic idle_wake;
  logic tb_exit;
  logic warm_done;
  logic osc_fault_r;
  logic tb_latch_r;
  logic tb_srv_r;
  logic wake_srv_r;
  logic resume_r;

  omc_reset_sync u_rst (
    .clk(clk),
    .reset_n(reset_n),
    .rst_n_sync(rst_n_s)
  );

  omc_edge_sync u_wake (
    .clk(clk),
    .rst_n(rst_n_s),
    .async_in(wake_pin),
    .rise(wake_rise),
    .fall()
  );

  // time base source comes from another clock, so it is synchronised
  omc_edge_sync u_tbsrc (
    .clk(clk),
    .rst_n(rst_n_s),
    .async_in(timebase_src),
    .rise(),
    .fall(tb_fall)
  );

  function automatic logic is_lf(input omc_state_t s);
    is_lf = (s == ST_LF_RUN_HF_ON) || (s == ST_LF_SLEEP_HF_ON) || (s == ST_LF_RUN_HF_OFF) ||
            (s == ST_LF_SLEEP_HF_OFF) || (s == ST_LF_TIMEBASE_HALT);
  endfunction

  function automatic logic is_dual(input omc_state_t s);
    is_dual = is_lf(s) || (s == ST_HF_RUN_DUAL) || (s == ST_HF_IDLE_DUAL);
  endfunction

  function automatic logic hf_on(input omc_state_t s);
    hf_on = (s != ST_LF_RUN_HF_OFF) && (s != ST_LF_SLEEP_HF_OFF) && (s != ST_LF_TIMEBASE_HALT);
  endfunction

  function automatic logic is_run(input omc_state_t s);
    is_run = (s == ST_HF_RUN_SINGLE) || (s == ST_HF_RUN_DUAL) || (s == ST_LF_RUN_HF_ON) ||
             (s == ST_LF_RUN_HF_OFF);
  endfunction

  // bus slave: zero wait states, read data captured in the address phase
  assign hreadyout = 1'b1;
  assign hresp = RESP_OKAY;
  assign hrdata = hrdata_r;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= '0;
    end else if (hsel && hready && htrans[1]) begin
      dp_wr_r <= hwrite && (hsize == SIZE_WORD);
      dp_addr_r <= haddr[ADDR_LSB_W-1:0];
    end else begin
      dp_wr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      hrdata_r <= '0;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[ADDR_LSB_W-1:0])
        OFS_CTRL2: begin
          // idle and halt bits read back from the state, so they drop on exit
          hrdata_r <= 32'({hf_en_r, lf_en_r, sysclk_is_lf,
                           (state_r == ST_HF_IDLE_SINGLE) || (state_r == ST_HF_IDLE_DUAL) ||
                           (state_r == ST_LF_SLEEP_HF_ON) || (state_r == ST_LF_SLEEP_HF_OFF),
                           1'b0,
                           (state_r == ST_HF_TIMEBASE_HALT) || (state_r == ST_LF_TIMEBASE_HALT),
                           2'b00});
        end
        OFS_TBCTRL: begin
          hrdata_r <= 32'({tb_sel_r, tb_en_r});
        end
        OFS_STATUS: begin
          hrdata_r <= 32'({lf_pins_are_io, 4'(state_r)});
        end
        default: begin
          hrdata_r <= '0;
        end
      endcase
    end
  end

  assign wd = hwdata[7:0];
  assign wr_ctrl1 = dp_wr_r && (dp_addr_r == OFS_CTRL1);
  assign wr_ctrl2 = dp_wr_r && (dp_addr_r == OFS_CTRL2);
  assign wr_tb = dp_wr_r && (dp_addr_r == OFS_TBCTRL);
  assign halt_req = wr_ctrl1 && wd[CTRL1_HALT_BIT];
  assign idle_req = wr_ctrl2 && wd[CTRL2_IDLE_BIT];
  // idle wins if firmware sets both at once
  assign tgh_req = wr_ctrl2 && wd[CTRL2_TGH_BIT] && !wd[CTRL2_IDLE_BIT];
  assign osc_fault = wr_ctrl2 && ((!wd[CTRL2_HF_BIT] && !wd[CTRL2_LF_BIT]) ||
                     (!wd[CTRL2_HF_BIT] && !sysclk_is_lf) || (!wd[CTRL2_LF_BIT] && sysclk_is_lf));
  assign any_irq = peripheral_irq || external_irq;
  assign idle_wake = any_irq && ((state_r == ST_HF_IDLE_SINGLE) || (state_r == ST_HF_IDLE_DUAL) ||
                     (state_r == ST_LF_SLEEP_HF_ON) || (state_r == ST_LF_SLEEP_HF_OFF));
  assign tb_exit = tb_fall && ((state_r == ST_HF_TIMEBASE_HALT) || (state_r == ST_LF_TIMEBASE_HALT));
  assign warm_done = (state_r == ST_WARMUP) && (warm_cnt_r == '0);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HF_RUN_SINGLE: begin
        if (halt_req) state_nxt = ST_HALT_ALL;
        else if (idle_req) state_nxt = ST_HF_IDLE_SINGLE;
        else if (tgh_req) state_nxt = ST_HF_TIMEBASE_HALT;
        else if (wr_ctrl2 && wd[CTRL2_LF_BIT]) state_nxt = ST_HF_RUN_DUAL;
      end
      ST_HF_RUN_DUAL: begin
        if (halt_req) state_nxt = ST_HALT_ALL;
        else if (idle_req) state_nxt = ST_HF_IDLE_DUAL;
        else if (wr_ctrl2 && wd[CTRL2_SYSCLK_SELECT_BIT]) state_nxt = ST_LF_RUN_HF_ON;
        else if (wr_ctrl2 && !wd[CTRL2_LF_BIT]) state_nxt = ST_HF_RUN_SINGLE;
      end
      ST_LF_RUN_HF_ON: begin
        if (halt_req) state_nxt = ST_HALT_ALL;
        else if (idle_req) state_nxt = ST_LF_SLEEP_HF_ON;
        else if (wr_ctrl2 && !wd[CTRL2_SYSCLK_SELECT_BIT]) state_nxt = ST_HF_RUN_DUAL;
        else if (wr_ctrl2 && !wd[CTRL2_HF_BIT]) state_nxt = ST_LF_RUN_HF_OFF;
      end
      ST_LF_RUN_HF_OFF: begin
        if (halt_req) state_nxt = ST_HALT_ALL;
        else if (idle_req) state_nxt = ST_LF_SLEEP_HF_OFF;
        else if (tgh_req) state_nxt = ST_LF_TIMEBASE_HALT;
        else if (wr_ctrl2 && wd[CTRL2_HF_BIT]) state_nxt = ST_LF_RUN_HF_ON;
      end
      ST_HF_IDLE_SINGLE: if (any_irq) state_nxt = ST_HF_RUN_SINGLE;
      ST_HF_IDLE_DUAL: if (any_irq) state_nxt = ST_HF_RUN_DUAL;
      ST_LF_SLEEP_HF_ON: if (any_irq) state_nxt = ST_LF_RUN_HF_ON;
      ST_LF_SLEEP_HF_OFF: if (any_irq) state_nxt = ST_LF_RUN_HF_OFF;
      ST_HF_TIMEBASE_HALT: if (tb_fall) state_nxt = ST_HF_RUN_SINGLE;
      ST_LF_TIMEBASE_HALT: if (tb_fall) state_nxt = ST_LF_RUN_HF_OFF;
      ST_HALT_ALL: if (wake_rise) state_nxt = ST_WARMUP;
      ST_WARMUP: if (warm_cnt_r == '0) state_nxt = ret_r;
      default: state_nxt = ST_HF_RUN_SINGLE;
    endcase
    // any event not listed above keeps the state; unused state codes fall to ST_HF_RUN_SINGLE
    if (osc_fault) state_nxt = ST_HF_RUN_SINGLE;
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= ST_HF_RUN_SINGLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ret_r <= ST_HF_RUN_SINGLE;
    end else if (state_nxt == ST_HALT_ALL && state_r != ST_HALT_ALL) begin
      ret_r <= state_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      warm_cnt_r <= '0;
    end else if (state_r == ST_HALT_ALL) begin
      warm_cnt_r <= WARM_W'(WARM_CYCLES - 1);
    end else if (state_r == ST_WARMUP && warm_cnt_r != '0) begin
      warm_cnt_r <= warm_cnt_r - 1'b1;
    end
  end

  // internal reset restores the enables as a real reset would
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      hf_en_r <= HF_EN_RST;
      lf_en_r <= LF_EN_RST;
    end else if (osc_fault) begin
      hf_en_r <= HF_EN_RST;
      lf_en_r <= LF_EN_RST;
    end else if (wr_ctrl2 && (state_nxt != state_r || is_run(state_r))) begin
      hf_en_r <= wd[CTRL2_HF_BIT];
      lf_en_r <= wd[CTRL2_LF_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tb_en_r <= 1'b0;
      tb_sel_r <= TB_SEL_RST;
    end else if (wr_tb) begin
      tb_en_r <= wd[TB_EN_BIT];
      tb_sel_r <= wd[TB_SEL_LSB +: TB_SEL_W];
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tb_at_entry_r <= 1'b0;
    end else if (tgh_req && (state_nxt != state_r)) begin
      tb_at_entry_r <= tb_en_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      osc_fault_r <= 1'b0;
      tb_latch_r <= 1'b0;
      tb_srv_r <= 1'b0;
      wake_srv_r <= 1'b0;
      resume_r <= 1'b0;
    end else begin
      osc_fault_r <= osc_fault;
      tb_latch_r <= tb_exit && tb_at_entry_r;
      tb_srv_r <= tb_exit && tb_at_entry_r && master_irq_enable && timebase_irq_enable;
      wake_srv_r <= idle_wake && master_irq_enable;
      resume_r <= (idle_wake && !master_irq_enable) || warm_done;
    end
  end

  // halt-all and warm-up borrow the mode they will return to
  assign mode_s = (state_r == ST_HALT_ALL || state_r == ST_WARMUP) ? ret_r : state_r;
  assign cpu_wdt_clk_en = is_run(state_r);
  assign periph_hf_clk_en = hf_on(state_r) && (state_r != ST_HF_TIMEBASE_HALT) &&
                            (state_r != ST_HALT_ALL) && (state_r != ST_WARMUP);
  assign periph_lf_clk_en = is_dual(state_r) && (state_r != ST_LF_TIMEBASE_HALT);
  assign tbt_clk_en = (state_r != ST_HALT_ALL) && (state_r != ST_WARMUP);
  assign hf_osc_run = (state_r != ST_HALT_ALL) && hf_on(mode_s);
  assign lf_osc_run = (state_r != ST_HALT_ALL) && is_dual(mode_s);
  assign sysclk_is_lf = is_lf(state_r);
  assign lf_pins_are_io = !is_dual(mode_s);
  assign div_low_stages_run = hf_osc_run;
  assign timebase_enable = tb_en_r;
  assign timebase_source_select = tb_sel_r;
  assign osc_fault_reset = osc_fault_r;
  assign timebase_irq_latch_set = tb_latch_r;
  assign timebase_irq_service = tb_srv_r;
  assign wake_irq_service = wake_srv_r;
  assign wake_resume_next = resume_r;

  sequence s_idle_req;
    state_r == ST_HF_RUN_SINGLE && idle_req && !osc_fault;
  endsequence
  sequence s_single_wake;
    state_r == ST_HF_IDLE_SINGLE && any_irq;
  endsequence
  sequence s_tb_exit;
    state_r == ST_HF_TIMEBASE_HALT && tb_fall;
  endsequence

  property p_reset_state;
    @(posedge clk) disable iff (!rst_n_s)
    $rose(rst_n_s) |-> state_r == ST_HF_RUN_SINGLE && hf_osc_run && !lf_osc_run && cpu_wdt_clk_en;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("not in hf single run after reset");

  property p_single_osc;
    @(posedge clk) disable iff (!rst_n_s)
    state_r == ST_HF_RUN_SINGLE |-> hf_osc_run && !lf_osc_run && !sysclk_is_lf && lf_pins_are_io;
  endproperty
  a_single_osc: assert property (p_single_osc) else $error("single-clock oscillator mix wrong");

  property p_dual_pins;
    @(posedge clk) disable iff (!rst_n_s)
    lf_osc_run |-> !lf_pins_are_io;
  endproperty
  a_dual_pins: assert property (p_dual_pins) else $error("lf pins still I/O in dual mode");

  property p_idle_entry;
    @(posedge clk) disable iff (!rst_n_s)
    s_idle_req |=> state_r == ST_HF_IDLE_SINGLE && !cpu_wdt_clk_en && periph_hf_clk_en;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

  property p_idle_wake;
    @(posedge clk) disable iff (!rst_n_s)
    s_single_wake |=> state_r == ST_HF_RUN_SINGLE && wake_irq_service == $past(master_irq_enable) &&
                      wake_resume_next == !$past(master_irq_enable);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

  property p_tb_exit;
    @(posedge clk) disable iff (!rst_n_s)
    s_tb_exit |=> state_r == ST_HF_RUN_SINGLE && timebase_irq_latch_set == $past(tb_at_entry_r);
  endproperty
  a_tb_exit: assert property (p_tb_exit) else $error("timebase halt exit wrong");

  property p_halt_hold;
    @(posedge clk) disable iff (!rst_n_s)
    state_r == ST_HALT_ALL && !wake_rise |=> state_r == ST_HALT_ALL && !hf_osc_run && !lf_osc_run;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt-all left without wake");

  property p_warm_return;
    @(posedge clk) disable iff (!rst_n_s)
    warm_done |=> state_r == $past(ret_r) && wake_resume_next;
  endproperty
  a_warm_return: assert property (p_warm_return) else $error("warm-up return wrong");

  property p_osc_fault;
    @(posedge clk) disable iff (!rst_n_s)
    osc_fault |=> osc_fault_reset && state_r == ST_HF_RUN_SINGLE ##1 !osc_fault_reset || osc_fault;
  endproperty
  a_osc_fault: assert property (p_osc_fault) else $error("oscillator fault reset wrong");

  property p_sysclk_select_switch;
    @(posedge clk) disable iff (!rst_n_s)
    state_r == ST_HF_RUN_DUAL && wr_ctrl2 && wd[CTRL2_SYSCLK_SELECT_BIT] && !wd[CTRL2_IDLE_BIT] && !osc_fault
    |=> state_r == ST_LF_RUN_HF_ON && sysclk_is_lf && hf_osc_run;
  endproperty
  a_sysclk_select_switch: assert property (p_sysclk_select_switch) else $error("clock select switch wrong");

  property p_no_transition;
    @(posedge clk) disable iff (!rst_n_s)
    state_r == ST_HF_RUN_SINGLE && wr_ctrl2 && wd[CTRL2_HF_BIT] && !wd[CTRL2_LF_BIT] &&
    !wd[CTRL2_IDLE_BIT] && !wd[CTRL2_TGH_BIT] |=> $stable(state_r);
  endproperty
  a_no_transition: assert property (p_no_transition) else $error("state moved on a no-op write");
endmodule // omc_ctrl
`default_nettype wire

// ===== hdl/omc_pkg.sv
package omc_pkg;
  localparam logic [3:0] OFS_CTRL1 = 4'h0;
  localparam logic [3:0] OFS_CTRL2 = 4'h4;
  localparam logic [3:0] OFS_TBCTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam int ADDR_LSB_W = 4;
  localparam logic [2:0] SIZE_WORD = 3'b010;
  localparam logic RESP_OKAY = 1'b0;
  localparam int CTRL1_HALT_BIT = 7;
  localparam int CTRL2_HF_BIT = 7;
  localparam int CTRL2_LF_BIT = 6;
  localparam int CTRL2_SYSCLK_SELECT_BIT = 5;
  localparam int CTRL2_IDLE_BIT = 4;
  localparam int CTRL2_TGH_BIT = 2;
  localparam int TB_EN_BIT = 0;
  localparam int TB_SEL_LSB = 1;
  localparam int TB_SEL_W = 3;
  localparam int STAT_IO_BIT = 4;
  localparam logic HF_EN_RST = 1'b1;
  localparam logic LF_EN_RST = 1'b0;
  localparam logic [TB_SEL_W-1:0] TB_SEL_RST = 3'h0;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WARMUP_TIME_NS = 4000;
  localparam int WARMUP_CYCLES = (WARMUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_W = 16;
  typedef enum logic [3:0] {
    ST_HF_RUN_SINGLE,
    ST_HF_IDLE_SINGLE,
    ST_HF_TIMEBASE_HALT,
    ST_HF_RUN_DUAL,
    ST_HF_IDLE_DUAL,
    ST_LF_RUN_HF_ON,
    ST_LF_SLEEP_HF_ON,
    ST_LF_RUN_HF_OFF,
    ST_LF_SLEEP_HF_OFF,
    ST_LF_TIMEBASE_HALT,
    ST_HALT_ALL,
    ST_WARMUP
  } omc_state_t;
endpackage

// ===== hdl/omc_reset_sync.sv
`timescale 1ns/100ps
`default_nettype none
module omc_reset_sync (
  input wire logic clk,
  input wire logic reset_n,
  output logic rst_n_sync
);
  logic s1_r;
  logic s2_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= 1'b1;
      s2_r <= s1_r;
    end
  end
  assign rst_n_sync = s2_r;
endmodule // omc_reset_sync
`default_nettype wire

// ===== hdl/omc_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none
module omc_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // only s2_r and s3_r feed the edge logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule // omc_edge_sync
`default_nettype wire

// ===== dv/omc_partner.sv
`timescale 1ns/100ps
`default_nettype none
module omc_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tb_run,
  input wire logic slow,
  input wire logic irq_req,
  output logic timebase_src,
  output logic peripheral_irq
);
  logic [1:0] div_r;
  // source idles where it stopped, so only a running source makes the waking fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 2'h0;
      timebase_src <= 1'b1;
    end else if (tb_run) begin
      div_r <= div_r + 2'h1;
      if (slow ? (div_r == 2'h3) : div_r[0]) begin
        timebase_src <= ~timebase_src;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_irq <= 1'b0;
    end else begin
      peripheral_irq <= irq_req;
    end
  end
endmodule // omc_partner
`default_nettype wire

// ===== dv/operating_mode_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
module operating_mode_controller_tb;
  import omc_pkg::*;
  logic clk, reset_n, hsel, hwrite, external_irq, master_irq_enable, timebase_irq_enable, wake_pin;
  logic tb_run, slow, irq_req, dp_rd, timebase_src, peripheral_irq, hreadyout, hresp, timebase_enable;
  logic cpu_wdt_clk_en, periph_hf_clk_en, periph_lf_clk_en, tbt_clk_en, hf_osc_run, lf_osc_run;
  logic sysclk_is_lf, lf_pins_are_io, div_low_stages_run, osc_fault_reset, timebase_irq_latch_set;
  logic timebase_irq_service, wake_irq_service, wake_resume_next;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [TB_SEL_W-1:0] timebase_source_select;
  logic [15:0] rnd;
  logic [4:0] pv;
  logic [8:0] lv;
  logic [31:0] rd_q[$];
  logic [4:0] ev_q[$];
  int errors;
  int comparisons;
  assign pv = {osc_fault_reset, timebase_irq_latch_set, timebase_irq_service, wake_irq_service, wake_resume_next};
  assign lv = {cpu_wdt_clk_en, periph_hf_clk_en, periph_lf_clk_en, tbt_clk_en, hf_osc_run, lf_osc_run,
    sysclk_is_lf, lf_pins_are_io, div_low_stages_run};
  omc_ctrl #(.WARM_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .peripheral_irq(peripheral_irq), .external_irq(external_irq),
    .master_irq_enable(master_irq_enable), .timebase_irq_enable(timebase_irq_enable), .wake_pin(wake_pin),
    .timebase_src(timebase_src), .timebase_source_select(timebase_source_select),
    .timebase_enable(timebase_enable), .cpu_wdt_clk_en(cpu_wdt_clk_en), .periph_hf_clk_en(periph_hf_clk_en),
    .periph_lf_clk_en(periph_lf_clk_en), .tbt_clk_en(tbt_clk_en), .hf_osc_run(hf_osc_run),
    .lf_osc_run(lf_osc_run), .sysclk_is_lf(sysclk_is_lf), .lf_pins_are_io(lf_pins_are_io),
    .div_low_stages_run(div_low_stages_run), .osc_fault_reset(osc_fault_reset),
    .timebase_irq_latch_set(timebase_irq_latch_set), .timebase_irq_service(timebase_irq_service),
    .wake_irq_service(wake_irq_service), .wake_resume_next(wake_resume_next));
  omc_partner u_far (.clk(clk), .rst_n(reset_n), .tb_run(tb_run), .slow(slow), .irq_req(irq_req),
    .timebase_src(timebase_src), .peripheral_irq(peripheral_irq));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_ev(input logic [4:0] e, input logic [4:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch pulses expected %b seen %b", e, g);
    end
  endtask
  task guard(input int n);
    if (n > 400) begin
      errors++;
      $display("mismatch wait expected done seen timeout");
      tally_and_finish;
    end
  endtask
  // one master, so hready is the slave's own hreadyout
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {28'h000_0000, a};
    hwrite <= wr;
    hsize <= SIZE_WORD;
    if (!wr) rd_q.push_back({24'h00_0000, d});
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
        guard(n);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
    end
  endtask
  task st(input omc_state_t s, input logic io);
    bus(1'b0, OFS_STATUS, {3'h0, io, s});
  endtask
  task lvl(input logic [8:0] e, input logic [8:0] m);
    @(negedge clk);
    chk("clocks", {23'h00_0000, e & m}, {23'h00_0000, lv & m});
  endtask
  task wait_run;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      guard(n);
    end while (cpu_wdt_clk_en !== 1'b1);
  endtask
  task wake;
    rnd = nxt(rnd);
    @(posedge clk);
    master_irq_enable <= rnd[0];
    ev_q.push_back({3'b000, rnd[0], ~rnd[0]});
    if (rnd[1]) irq_req <= 1'b1;
    else external_irq <= 1'b1;
    wait_run;
    @(posedge clk);
    irq_req <= 1'b0;
    external_irq <= 1'b0;
  endtask
  task tbhalt(input logic [7:0] c, input omc_state_t hs, input omc_state_t bk, input logic io, input logic [7:0] rb);
    rnd = nxt(rnd);
    bus(1'b1, OFS_TBCTRL, {4'h0, rnd[3:1], rnd[0]});
    bus(1'b0, OFS_TBCTRL, {4'h0, rnd[3:1], rnd[0]});
    chk("tbctrl", {28'h000_0000, rnd[3:0]}, {28'h000_0000, timebase_source_select, timebase_enable});
    @(posedge clk);
    master_irq_enable <= rnd[4];
    timebase_irq_enable <= rnd[5];
    slow <= rnd[6];
    bus(1'b1, OFS_CTRL2, c);
    lvl(9'h020, 9'h1E0);
    st(hs, io);
    if (rnd[0]) ev_q.push_back({1'b0, 1'b1, rnd[4] & rnd[5], 2'b00});
    @(posedge clk);
    tb_run <= 1'b1;
    wait_run;
    @(posedge clk);
    tb_run <= 1'b0;
    st(bk, io);
    bus(1'b0, OFS_CTRL2, rb);
  endtask
  always @(posedge clk) begin
    if (dp_rd) begin
      chk("hrdata", rd_q.size() ? rd_q.pop_front() : 32'hxxxx_xxxx, hrdata);
      chk("hresp", {31'h0000_0000, RESP_OKAY}, {31'h0000_0000, hresp});
    end
    dp_rd <= hsel & htrans[1] & ~hwrite & hreadyout;
    // an unlooked-for or unknown pulse must fail, so an empty queue expects silence
    if ((|pv) !== 1'b0) chk_ev(ev_q.size() ? ev_q.pop_front() : 5'b00000, pv);
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #800000;
    errors++;
    $display("mismatch run expected done seen timeout");
    tally_and_finish;
  end
  initial begin
    {reset_n, hsel, hwrite, external_irq, master_irq_enable, timebase_irq_enable} = 6'h00;
    {wake_pin, tb_run, slow, irq_req} = 4'h0;
    {haddr, hwdata, htrans, hsize} = 69'h0;
    rnd = 16'hAB94;
    errors = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    st(ST_HF_RUN_SINGLE, 1'b1);
    lvl(9'h1B3, 9'h1FF);
    bus(1'b0, OFS_CTRL2, 8'h80);
    bus(1'b0, OFS_TBCTRL, 8'h00);
    bus(1'b0, OFS_CTRL1, 8'h00);
    bus(1'b1, OFS_CTRL2, 8'h90);
    lvl(9'h0B3, 9'h1FF);
    st(ST_HF_IDLE_SINGLE, 1'b1);
    wake;
    st(ST_HF_RUN_SINGLE, 1'b1);
    bus(1'b0, OFS_CTRL2, 8'h80);
    tbhalt(8'h84, ST_HF_TIMEBASE_HALT, ST_HF_RUN_SINGLE, 1'b1, 8'h80);
    ev_q.push_back(5'b10000);
    bus(1'b1, OFS_CTRL2, 8'h00);
    st(ST_HF_RUN_SINGLE, 1'b1);
    bus(1'b0, OFS_CTRL2, 8'h80);
    bus(1'b1, OFS_CTRL2, 8'hC0);
    lvl(9'h1F9, 9'h1FF);
    bus(1'b1, OFS_CTRL2, 8'hC4);
    st(ST_HF_RUN_DUAL, 1'b0);
    bus(1'b1, OFS_CTRL2, 8'hD0);
    st(ST_HF_IDLE_DUAL, 1'b0);
    wake;
    st(ST_HF_RUN_DUAL, 1'b0);
    bus(1'b1, OFS_CTRL2, 8'hE0);
    lvl(9'h1FD, 9'h1FF);
    bus(1'b0, OFS_CTRL2, 8'hE0);
    bus(1'b1, OFS_CTRL2, 8'hF0);
    lvl(9'h0FD, 9'h1FF);
    wake;
    st(ST_LF_RUN_HF_ON, 1'b0);
    bus(1'b1, OFS_CTRL2, 8'h60);
    lvl(9'h16C, 9'h17F);
    bus(1'b1, OFS_CTRL2, 8'h70);
    st(ST_LF_SLEEP_HF_OFF, 1'b0);
    wake;
    st(ST_LF_RUN_HF_OFF, 1'b0);
    tbhalt(8'h64, ST_LF_TIMEBASE_HALT, ST_LF_RUN_HF_OFF, 1'b0, 8'h60);
    bus(1'b1, OFS_CTRL2, 8'hE0);
    st(ST_LF_RUN_HF_ON, 1'b0);
    bus(1'b1, OFS_CTRL2, 8'hC0);
    st(ST_HF_RUN_DUAL, 1'b0);
    bus(1'b1, OFS_CTRL2, 8'hE0);
    ev_q.push_back(5'b10000);
    bus(1'b1, OFS_CTRL2, 8'hA0);
    st(ST_HF_RUN_SINGLE, 1'b1);
    bus(1'b1, OFS_CTRL2, 8'hC0);
    bus(1'b1, OFS_CTRL1, 8'h80);
    lvl(9'h000, 9'h118);
    ev_q.push_back(5'b00001);
    @(posedge clk);
    wake_pin <= 1'b1;
    wait_run;
    @(posedge clk);
    wake_pin <= 1'b0;
    st(ST_HF_RUN_DUAL, 1'b0);
    bus(1'b1, OFS_CTRL2, 8'h80);
    st(ST_HF_RUN_SINGLE, 1'b1);
    bus(1'b1, OFS_CTRL2, 8'hC0);
    ev_q.push_back(5'b10000);
    bus(1'b1, OFS_CTRL2, 8'h40);
    st(ST_HF_RUN_SINGLE, 1'b1);
    bus(1'b1, OFS_CTRL2, 8'hA0);
    st(ST_HF_RUN_SINGLE, 1'b1);
    repeat (4) @(posedge clk);
    chk("pending", 32'h0000_0000, rd_q.size() + ev_q.size());
    tally_and_finish;
  end
endmodule // operating_mode_controller_tb
`default_nettype wire
